//--- hw/cmp_pkg.sv
// Package for the dual comparator control block: offsets, fields, reset values, carriers
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers
package cmp_pkg;
   localparam int unsigned NUM_CMP = 2;
   localparam logic [7:0] OFS_CTRL0_C1 = 8'h00;
   localparam logic [7:0] OFS_CTRL1_C1 = 8'h04;
   localparam logic [7:0] OFS_CTRL0_C2 = 8'h08;
   localparam logic [7:0] OFS_CTRL1_C2 = 8'h0C;
   localparam logic [7:0] OFS_MIRROR = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_ROUTE = 8'h18;
   localparam logic [7:0] CMP_STRIDE = 8'h08;
   // First control register fields
   localparam int unsigned B_ON = 7;
   localparam int unsigned B_RESULT = 6;
   localparam int unsigned B_INVERT = 4;
   localparam int unsigned B_HYS = 1;
   localparam int unsigned B_SYNC = 0;
   // Second control register fields
   localparam int unsigned B_RISE_EN = 7;
   localparam int unsigned B_FALL_EN = 6;
   localparam int unsigned B_PCH = 3;
   localparam int unsigned B_NCH = 0;
   // Route register: bits 0..1 select comparator 1/2 for the pin, bit 4 pin direction
   localparam int unsigned B_ROUTE_SEL = 0;
   localparam int unsigned B_PIN_DIR = 4;
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] ROUTE_RST = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic on;
      logic invert;
      logic hys;
      logic sync;
      logic rise_en;
      logic fall_en;
      logic [2:0] pch;
      logic [2:0] nch;
   } cmp_cfg_t;
endpackage

//--- hw/cmp_channel.sv
// One comparator channel: enable gating, polarity, sampling, timer sync, edge flag
// Assumes analog result already sampled by two flip-flops; timer clock level synchronised
`timescale 1ns/1ps
`default_nettype none
module cmp_channel
   import cmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire cmp_cfg_t cfg,
   input wire logic raw_sync,
   input wire logic tmr_fall,
   input wire logic flag_clr,
   output logic comb_out,
   output logic result_r,
   output logic synced_r,
   output logic flag_r
);
   logic prev_r;
   logic rise;
   logic fall;

   // Off comparator reads low unless inverted; invert applies after gating
   assign comb_out = (cfg.on & raw_sync) ^ cfg.invert;

   always_ff @(posedge clk) begin
      if (rst) begin
         result_r <= 1'b0;
      end else begin
         result_r <= comb_out;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         synced_r <= 1'b0;
      end else if (tmr_fall) begin
         synced_r <= comb_out;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= result_r;
      end
   end

   assign rise = result_r & ~prev_r;
   assign fall = ~result_r & prev_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if ((rise & cfg.rise_en) | (fall & cfg.fall_en)) begin
         flag_r <= 1'b1;
      end else if (flag_clr) begin
         flag_r <= 1'b0;
      end
   end

   AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
      (rise & cfg.rise_en & flag_clr) |=> flag_r)
      else $error("flag lost on clear");
   AST_RISE_FLAG: assert property (@(posedge clk) disable iff (rst)
      (rise & cfg.rise_en) |=> flag_r)
      else $error("rising edge flag missing");
   AST_FALL_FLAG: assert property (@(posedge clk) disable iff (rst)
      (fall & cfg.fall_en) |=> flag_r)
      else $error("falling edge flag missing");
   AST_SAMPLE: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> result_r == $past(comb_out))
      else $error("result not sampled");
   AST_OFF_LOW: assert property (@(posedge clk) disable iff (rst)
      (!cfg.on && !cfg.invert) [*2] |-> !result_r)
      else $error("disabled comparator not low");
   AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (rst)
      !tmr_fall |=> $stable(synced_r))
      else $error("sync output changed without timer edge");
   COV_RISE: cover property (@(posedge clk) disable iff (rst) rise && cfg.rise_en);
   COV_FALL: cover property (@(posedge clk) disable iff (rst) fall && cfg.fall_en);
   COV_CLR_RACE: cover property (@(posedge clk) disable iff (rst) rise && cfg.rise_en && flag_clr);
endmodule
`default_nettype wire

//--- hw/cmp_ctrl.sv
// Dual comparator digital control with AXI4-Lite register slave
// Assumes analog comparator results and timer clock arrive asynchronously from pins
//
// Function
// - Raw result high when noninverting input higher
// - Enable bit gates comparator; off is low-power
// - Result readable in control and mirror registers
// - Result routed to pin when direction output
// - Internal result registered every cycle
// - Pin output registered from the live result unless sync selected
// - Invert bit inverts reported result
// - Hysteresis bit switches input hysteresis
// - Two comparators, two control registers each
// - Sync captures on timer clock falling edge
// - Enabled edges set the interrupt flag
// - Software clears flag; simultaneous edge wins
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl
   import cmp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [NUM_CMP-1:0] cmp_raw,
   input wire logic tmr_clk,
   output logic [NUM_CMP-1:0] cmp_enable,
   output logic [NUM_CMP-1:0] cmp_hys_en,
   output logic [5:0] cmp_in_sel_0,
   output logic [5:0] cmp_in_sel_1,
   output logic pin_out,
   output logic pin_oe,
   output logic [NUM_CMP-1:0] cmp_flag,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Register map and pin routing serve exactly two comparators
   if (NUM_CMP != 2) begin : g_bad_num
      $error("two comparators only");
   end

   cmp_cfg_t cfg [NUM_CMP];
   logic [NUM_CMP-1:0] raw_m_r, raw_s_r, comb, result, synced, flag, clr;
   logic [2:0] tmr_r;
   logic tmr_fall;
   logic [7:0] route_r;
   logic [7:0] aw_r;
   logic [31:0] wd_r;
   logic [3:0] ws_r;
   logic aw_ok_r, w_ok_r;
   logic wr_go;
   logic [NUM_CMP-1:0] pin_val;

   // Two-stage synchronisers for pin-level inputs
   always_ff @(posedge clk) begin
      if (rst) begin
         raw_m_r <= '0;
         raw_s_r <= '0;
         tmr_r <= '0;
      end else begin
         raw_m_r <= cmp_raw;
         raw_s_r <= raw_m_r;
         tmr_r <= {tmr_r[1:0], tmr_clk};
      end
   end
   assign tmr_fall = tmr_r[2] & ~tmr_r[1];

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CMP; gi++) begin : g_ch
         cmp_channel u_ch (
            .clk(clk),
            .rst(rst),
            .cfg(cfg[gi]),
            .raw_sync(raw_s_r[gi]),
            .tmr_fall(tmr_fall),
            .flag_clr(clr[gi]),
            .comb_out(comb[gi]),
            .result_r(result[gi]),
            .synced_r(synced[gi]),
            .flag_r(flag[gi])
         );
         assign pin_val[gi] = cfg[gi].sync ? synced[gi] : comb[gi];
      end
   endgenerate

   // Write channel: address and data taken in either order
   assign wr_go = aw_ok_r & w_ok_r & ~s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         aw_r <= '0;
         wd_r <= '0;
         ws_r <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= ~aw_ok_r & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_ok_r & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_ok_r <= 1'b1;
            aw_r <= s_axi_awaddr[7:0];
         end else if (wr_go) begin
            aw_ok_r <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_ok_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
         end else if (wr_go) begin
            w_ok_r <= 1'b0;
         end
      end
   end

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_CTRL0_C1) || (a == OFS_CTRL1_C1) || (a == OFS_CTRL0_C2) ||
         (a == OFS_CTRL1_C2) || (a == OFS_MIRROR) || (a == OFS_FLAGS) || (a == OFS_ROUTE);
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= mapped(aw_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers per comparator
   generate
      for (gi = 0; gi < NUM_CMP; gi++) begin : g_cfg
         localparam logic [7:0] C0 = OFS_CTRL0_C1 + CMP_STRIDE * 8'(gi);
         localparam logic [7:0] C1 = OFS_CTRL1_C1 + CMP_STRIDE * 8'(gi);
         always_ff @(posedge clk) begin
            if (rst) begin
               cfg[gi] <= '0;
            end else if (wr_go && ws_r[0]) begin
               if (aw_r == C0) begin
                  cfg[gi].on <= wd_r[B_ON];
                  cfg[gi].invert <= wd_r[B_INVERT];
                  cfg[gi].hys <= wd_r[B_HYS];
                  cfg[gi].sync <= wd_r[B_SYNC];
               end
               if (aw_r == C1) begin
                  cfg[gi].rise_en <= wd_r[B_RISE_EN];
                  cfg[gi].fall_en <= wd_r[B_FALL_EN];
                  cfg[gi].pch <= wd_r[B_PCH +: 3];
                  cfg[gi].nch <= wd_r[B_NCH +: 3];
               end
            end
         end
         // Write one to clear a flag
         assign clr[gi] = wr_go && ws_r[0] && (aw_r == OFS_FLAGS) && wd_r[gi];
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         route_r <= ROUTE_RST;
      end else if (wr_go && ws_r[0] && aw_r == OFS_ROUTE) begin
         route_r <= wd_r[7:0];
      end
   end

   // Read channel
   function automatic logic [7:0] ctrl0_rd(input cmp_cfg_t c, input logic r);
      ctrl0_rd = '0;
      ctrl0_rd[B_ON] = c.on;
      ctrl0_rd[B_RESULT] = r;
      ctrl0_rd[B_INVERT] = c.invert;
      ctrl0_rd[B_HYS] = c.hys;
      ctrl0_rd[B_SYNC] = c.sync;
   endfunction

   function automatic logic [7:0] ctrl1_rd(input cmp_cfg_t c);
      ctrl1_rd = '0;
      ctrl1_rd[B_RISE_EN] = c.rise_en;
      ctrl1_rd[B_FALL_EN] = c.fall_en;
      ctrl1_rd[B_PCH +: 3] = c.pch;
      ctrl1_rd[B_NCH +: 3] = c.nch;
   endfunction

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr[7:0])
               OFS_CTRL0_C1: s_axi_rdata <= {24'h0, ctrl0_rd(cfg[0], result[0])};
               OFS_CTRL1_C1: s_axi_rdata <= {24'h0, ctrl1_rd(cfg[0])};
               OFS_CTRL0_C2: s_axi_rdata <= {24'h0, ctrl0_rd(cfg[1], result[1])};
               OFS_CTRL1_C2: s_axi_rdata <= {24'h0, ctrl1_rd(cfg[1])};
               OFS_MIRROR: s_axi_rdata <= {30'h0, result};
               OFS_FLAGS: s_axi_rdata <= {30'h0, flag};
               OFS_ROUTE: s_axi_rdata <= {24'h0, route_r};
               default: s_axi_rdata <= 32'h0;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Pin drive and analog control outputs from flip-flops
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         cmp_enable <= '0;
         cmp_hys_en <= '0;
         cmp_in_sel_0 <= '0;
         cmp_in_sel_1 <= '0;
         cmp_flag <= '0;
      end else begin
         pin_out <= |(route_r[B_ROUTE_SEL +: 2] & pin_val);
         pin_oe <= ~route_r[B_PIN_DIR] & (|route_r[B_ROUTE_SEL +: 2]);
         cmp_enable <= {cfg[1].on, cfg[0].on};
         cmp_hys_en <= {cfg[1].hys, cfg[0].hys};
         cmp_in_sel_0 <= {cfg[0].pch, cfg[0].nch};
         cmp_in_sel_1 <= {cfg[1].pch, cfg[1].nch};
         cmp_flag <= flag;
      end
   end

   AST_PIN_OE: assert property (@(posedge clk) disable iff (rst)
      route_r[B_PIN_DIR] |=> !pin_oe)
      else $error("pin driven while direction is input");
   AST_MIRROR_LOW: assert property (@(posedge clk) disable iff (rst)
      (!cfg[0].on && !cfg[0].invert) [*3] |-> !result[0])
      else $error("disabled comparator reads high");
   COV_PIN: cover property (@(posedge clk) disable iff (rst) pin_oe && pin_out);
   COV_WRITE: cover property (@(posedge clk) disable iff (rst) s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

//--- sim/cmp_analog_model.sv
// Analog side model: two comparator input pairs and the timer source clock
// Assumes the bench calls its tasks right after a rising edge of the system clock
`timescale 1ns/1ps
`default_nettype none
module cmp_analog_model (
   output logic [1:0] cmp_raw,
   output logic tmr_clk
);
   int vp[2];
   int vn[2];
   initial begin
      vp = '{0, 0};
      vn = '{1, 1};
      tmr_clk = 1'b1;
   end
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cmp_raw[i] = vp[i] > vn[i];
      end
   end
   task automatic set_in(input int i, input int p, input int n);
      vp[i] <= p;
      vn[i] <= n;
   endtask
   task automatic set_tmr(input logic lvl);
      tmr_clk <= lvl;
   endtask
endmodule
`default_nettype wire

//--- sim/test_analog_comparator_digital_control.sv
// Bench for the dual comparator block: register and pin tests over AXI4-Lite
// Assumes the analog model drives comparator results and the timer source clock
`timescale 1ns/1ps
`default_nettype none
module test_analog_comparator_digital_control
   import cmp_pkg::*;
;
   logic clk, rst, tmr, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe;
   logic [31:0] awaddr, wdata, araddr, rdata, d;
   logic [1:0] raw, bresp, rresp, cmp_enable, cmp_hys_en, cmp_flag, r;
   logic [5:0] sel0, sel1;
   logic [7:0] c0, c1;
   int fails, comparisons;

   cmp_analog_model am (.cmp_raw(raw), .tmr_clk(tmr));
   cmp_ctrl dut (
      .clk(clk), .rst(rst), .cmp_raw(raw), .tmr_clk(tmr), .cmp_enable(cmp_enable),
      .cmp_hys_en(cmp_hys_en), .cmp_in_sel_0(sel0), .cmp_in_sel_1(sel1), .pin_out(pin_out),
      .pin_oe(pin_oe), .cmp_flag(cmp_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic summarize();
      $display("TB: %0d comparisons, %0d mismatches", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      summarize();
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // Write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      logic aw, w, b;
      n = 0;
      awaddr <= {24'h0, a};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         aw = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
         n++;
      end while (!b && n < 50);
      @(posedge clk);
      if (!b) fails++;
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      logic ar, v;
      n = 0;
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         ar = arvalid && arready;
         v = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar) arvalid <= 1'b0;
         if (v) rready <= 1'b0;
         n++;
      end while (!v && n < 50);
      @(posedge clk);
      if (!v) fails++;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(d, e);
   endtask

   task automatic settle();
      repeat (8) @(posedge clk);
   endtask

   initial begin
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 32'h0;
      wdata = 32'h0;
      araddr = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk(OFS_CTRL0_C1, {24'h0, CTRL0_RST});
      rchk(OFS_CTRL1_C2, {24'h0, CTRL1_RST});
      rchk(OFS_ROUTE, {24'h0, ROUTE_RST});
      rchk(OFS_MIRROR, 32'h0);
      chk(pin_oe, 1'b0);
      rd(8'h1C);
      chk({d[31:2], r}, {30'h0, RESP_SLVERR});
      wr(8'h1C, 32'hFF);
      chk(r, RESP_SLVERR);
      $display("TB: reset test done");
      for (int i = 0; i < 2; i++) begin
         c0 = (i == 0) ? OFS_CTRL0_C1 : OFS_CTRL0_C2;
         c1 = (i == 0) ? OFS_CTRL1_C1 : OFS_CTRL1_C2;
         am.set_in(i, 5, 2);
         wr(c0, 32'h80);
         settle();
         rchk(c0, 32'hC0);
         rchk(OFS_MIRROR, 32'h1 << i);
         chk(cmp_enable[i], 1'b1);
         wr(c0, 32'h92);
         settle();
         rchk(c0, 32'h92);
         chk(cmp_hys_en[i], 1'b1);
         am.set_in(i, 1, 4);
         settle();
         rchk(c0, 32'hD2);
         wr(c1, 32'h2B);
         chk((i == 0) ? sel0 : sel1, 6'h2B);
         am.set_in(i, 5, 2);
         wr(c0, 32'h00);
         settle();
         rchk(c0, 32'h00);
         rchk(OFS_MIRROR, 32'h0);
         chk({cmp_enable[i], cmp_hys_en[i]}, 2'b00);
      end
      $display("TB: channel test done");
      wr(OFS_CTRL1_C1, 32'h80);
      am.set_in(0, 1, 4);
      wr(OFS_CTRL0_C1, 32'h80);
      settle();
      rchk(OFS_FLAGS, 32'h0);
      am.set_in(0, 5, 2);
      settle();
      rchk(OFS_FLAGS, 32'h1);
      chk(cmp_flag, 2'b01);
      wr(OFS_FLAGS, 32'h1);
      rchk(OFS_FLAGS, 32'h0);
      am.set_in(0, 1, 4);
      settle();
      rchk(OFS_FLAGS, 32'h0);
      // Rising edge lands in the same cycle as the clear write
      am.set_in(0, 5, 2);
      @(posedge clk);
      wr(OFS_FLAGS, 32'h1);
      rchk(OFS_FLAGS, 32'h1);
      wr(OFS_FLAGS, 32'h1);
      wr(OFS_CTRL1_C1, 32'h40);
      am.set_in(0, 5, 2);
      settle();
      rchk(OFS_FLAGS, 32'h0);
      am.set_in(0, 1, 4);
      settle();
      rchk(OFS_FLAGS, 32'h1);
      wr(OFS_CTRL1_C1, 32'h80);
      wr(OFS_CTRL0_C1, 32'h00);
      settle();
      wr(OFS_FLAGS, 32'h1);
      wr(OFS_CTRL0_C1, 32'h10);
      settle();
      rchk(OFS_FLAGS, 32'h1);
      wr(OFS_FLAGS, 32'h1);
      $display("TB: flag test done");
      wr(OFS_CTRL0_C1, 32'h80);
      am.set_in(0, 5, 2);
      wr(OFS_ROUTE, 32'h01);
      settle();
      chk({pin_oe, pin_out}, 2'b11);
      am.set_in(0, 1, 4);
      settle();
      chk(pin_out, 1'b0);
      wr(OFS_ROUTE, 32'h11);
      settle();
      chk(pin_oe, 1'b0);
      wr(OFS_ROUTE, 32'h01);
      wr(OFS_CTRL0_C1, 32'h81);
      am.set_tmr(1'b0);
      settle();
      am.set_tmr(1'b1);
      am.set_in(0, 5, 2);
      settle();
      chk(pin_out, 1'b0);
      am.set_tmr(1'b0);
      settle();
      chk(pin_out, 1'b1);
      $display("TB: pin test done");
      summarize();
   end
endmodule
`default_nettype wire
